// ### rtl/irapm_defines.svh
// constants for the indirect register access and power mode block
`ifndef IRAPM_DEFINES_SVH
`define IRAPM_DEFINES_SVH

// direct register addresses (6-bit spi address space)
`define IRAPM_ADDR_W      6
`define IRAPM_PTR_ADDR    6'h3e
`define IRAPM_WIN_ADDR    6'h3f
`define IRAPM_PWR_ADDR    6'h03

// power mode register fields
`define IRAPM_SEL_BIT     0
`define IRAPM_AUTO_BIT    1
`define IRAPM_XTAL_BIT    4
`define IRAPM_PWR_WMASK   8'h13
`define IRAPM_PWR_RESET   8'h10

// reset values of the pointer and the data window, and the pointer step
`define IRAPM_PTR_RESET   8'h00
`define IRAPM_WIN_RESET   8'h00
`define IRAPM_PTR_STEP    8'h01

`endif

// ### rtl/irapm_pkg.sv
// types shared by the indirect register access and power mode block
package irapm_pkg;

	// transfer phase of the current spi register transaction
	typedef enum logic [1:0] {
		irapm_xfer_idle,
		irapm_xfer_direct,
		irapm_xfer_ptr,
		irapm_xfer_window
	} irapm_xfer_type;

	// device power state from crystal enable and power select
	typedef enum logic [1:0] {
		irapm_pstate_hibernate,
		irapm_pstate_doze,
		irapm_pstate_idle,
		irapm_pstate_unlisted
	} irapm_pstate_type;

endpackage : irapm_pkg

// ### rtl/irapm_pmc_select.sv
// power management controller mode and power state selection
`timescale 1ns/1ps
`include "irapm_defines.svh"

module irapm_pmc_select (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        reset_n,
	// control bits and sequencer state
	input  wire logic                        auto_low_power_enable,
	input  wire logic                        regulator_power_select,
	input  wire logic                        crystal_osc_enable,
	input  wire logic                        seq_active,
	// selected mode and state
	output logic                             high_power_q,
	output irapm_pkg::irapm_pstate_type      power_state_q
);

	logic                        high_power_d;   // next regulator mode
	irapm_pkg::irapm_pstate_type power_state_d;  // next power state

	// ***********************************************
	// mode and state selection
	// ***********************************************

	// next mode and state
	always_comb begin
		if (auto_low_power_enable) begin
			high_power_d = seq_active;                      // [R1]
		end else begin
			high_power_d = regulator_power_select;          // [R2] [R3]
		end
		case ({crystal_osc_enable, regulator_power_select})
			2'b00:   power_state_d = irapm_pkg::irapm_pstate_hibernate; // [R13]
			2'b10:   power_state_d = irapm_pkg::irapm_pstate_doze;      // [R13]
			2'b11:   power_state_d = irapm_pkg::irapm_pstate_idle;      // [R13]
			default: power_state_d = irapm_pkg::irapm_pstate_unlisted;
		endcase
	end

	// register mode and state
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			high_power_q  <= 1'b0;
			power_state_q <= irapm_pkg::irapm_pstate_hibernate;
		end else begin
			high_power_q  <= high_power_d;
			power_state_q <= power_state_d;
		end
	end

	// ***********************************************
	// checks
	// ***********************************************

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	auto_seq_high_a: assert property (auto_low_power_enable && seq_active |=> high_power_q) // [R1]
		else $error("auto mode not high power in sequence");
	auto_idle_low_a: assert property (auto_low_power_enable && !seq_active |=> !high_power_q) // [R1]
		else $error("auto mode not low power outside sequence");
	manual_follow_a: assert property (!auto_low_power_enable |=>
		high_power_q == $past(regulator_power_select)) // [R2]
		else $error("manual mode does not follow select bit");
	select_low_a: assert property (!auto_low_power_enable && !regulator_power_select
		##1 !auto_low_power_enable && !regulator_power_select |=> !high_power_q) // [R3]
		else $error("select zero did not give low power");
	state_map_a: assert property (crystal_osc_enable && !regulator_power_select |=>
		power_state_q == irapm_pkg::irapm_pstate_doze) // [R13]
		else $error("doze state not decoded");
	hib_map_a: assert property (!crystal_osc_enable && !regulator_power_select |=>
		power_state_q == irapm_pkg::irapm_pstate_hibernate) // [R13]
		else $error("hibernate state not decoded");

endmodule : irapm_pmc_select

// ### rtl/irapm_top.sv
// spi register side: indirect pointer, data window and power mode register
`timescale 1ns/1ps
`include "irapm_defines.svh"

// What this block does
// (R1) auto mode: high power only during sequences
// (R2) manual mode: power select bit sets mode
// (R3) select bit zero low power, one high
// (R4) pointer address loads pointer, then indirect access
// (R5) pointer increments after each indirect burst byte, except in hibernate
// (R6) host avoids indirect bursts in hibernate
// (R7) direct bursts auto-increment in every state
// (R8) soft reset leaves the pointer untouched
// (R9) window byte goes to pointer-selected register
// (R10) window inherits target access; read-only ignores writes
// (R11) window register at 3fh, resets zero
// (R12) pointer at 3eh, window at 3fh
// (R13) crystal and select bits give power state
module irapm_top (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        reset_n,
	// byte stream from the spi framer
	input  wire logic                        ctl_valid,
	input  wire logic [`IRAPM_ADDR_W-1:0]    ctl_addr,
	input  wire logic                        ctl_read,
	input  wire logic                        data_valid,
	input  wire logic [7:0]                  data_wr,
	input  wire logic                        xfer_end,
	// read answer to the spi framer
	output logic [7:0]                       rd_data_q,
	output logic                             rd_valid_q,
	// indirect register space
	output logic [7:0]                       ind_addr_q,
	output logic [7:0]                       ind_wr_addr_q,
	output logic [7:0]                       ind_wdata_q,
	output logic                             ind_we_q,
	output logic                             ind_re_q,
	input  wire logic [7:0]                  ind_rdata,
	input  wire logic                        ind_writable,
	// soft reset and sequence manager
	input  wire logic                        soft_reset,
	input  wire logic                        seq_active,
	// power management
	output logic                             pmc_high_power_q,
	output irapm_pkg::irapm_pstate_type      power_state_q,
	output logic                             crystal_osc_enable_q
);

	// ***********************************************
	// state
	// ***********************************************

	irapm_pkg::irapm_xfer_type   xfer_q;        // current transfer phase
	irapm_pkg::irapm_xfer_type   xfer_d;
	logic [`IRAPM_ADDR_W-1:0]    addr_q;        // direct address of current phase
	logic [`IRAPM_ADDR_W-1:0]    addr_d;
	logic                        read_q;        // transaction is a read
	logic                        read_d;
	logic [7:0]                  ptr_q;         // indirect pointer
	logic [7:0]                  ptr_d;
	logic [7:0]                  win_q;         // data window, last byte moved
	logic [7:0]                  win_d;
	logic [7:0]                  pwr_q;         // power mode register
	logic [7:0]                  pwr_d;
	logic [7:0]                  rd_data_d;
	logic                        rd_valid_d;
	logic [7:0]                  ind_wr_addr_d;
	logic [7:0]                  ind_wdata_d;
	logic                        ind_we_d;
	logic                        ind_re_d;
	logic                        hibernate;     // device in hibernate state
	logic [`IRAPM_ADDR_W-1:0]    addr_inc;      // next direct address in a burst

	// ***********************************************
	// address decode
	// ***********************************************

	// phase that a given direct address starts
	function automatic irapm_pkg::irapm_xfer_type mode_of(
		input logic [`IRAPM_ADDR_W-1:0] a
	);
		if (a == `IRAPM_PTR_ADDR) begin
			return irapm_pkg::irapm_xfer_ptr;       // [R12]
		end else if (a == `IRAPM_WIN_ADDR) begin
			return irapm_pkg::irapm_xfer_window;    // [R11] [R12]
		end else begin
			return irapm_pkg::irapm_xfer_direct;
		end
	endfunction : mode_of

	assign hibernate = (power_state_q == irapm_pkg::irapm_pstate_hibernate);
	assign addr_inc  = addr_q + `IRAPM_ADDR_W'(1);

	// ***********************************************
	// transaction and register logic
	// ***********************************************

	// next values of all transfer and register state
	always_comb begin
		xfer_d        = xfer_q;
		addr_d        = addr_q;
		read_d        = read_q;
		ptr_d         = ptr_q;
		win_d         = win_q;
		pwr_d         = pwr_q;
		rd_data_d     = rd_data_q;
		rd_valid_d    = 1'b0;
		ind_wr_addr_d = ind_wr_addr_q;
		ind_wdata_d   = ind_wdata_q;
		ind_we_d      = 1'b0;
		ind_re_d      = 1'b0;
		if (ctl_valid) begin
			// control word: latch address, direction and phase
			addr_d = ctl_addr;
			read_d = ctl_read;
			xfer_d = mode_of(ctl_addr);                 // [R4] [R12]
		end else if (data_valid) begin
			case (xfer_q)
				irapm_pkg::irapm_xfer_ptr: begin
					// byte after the control word becomes the pointer
					ptr_d      = data_wr;                   // [R4]
					rd_data_d  = ptr_q;
					rd_valid_d = read_q;
					xfer_d     = irapm_pkg::irapm_xfer_window; // [R4]
				end
				irapm_pkg::irapm_xfer_window: begin
					// access the register the pointer selects
					if (read_q) begin
						rd_data_d  = ind_rdata;             // [R9]
						rd_valid_d = 1'b1;
						ind_re_d   = 1'b1;
						win_d      = ind_rdata;
					end else if (ind_writable) begin
						ind_we_d      = 1'b1;               // [R9] [R10]
						ind_wr_addr_d = ptr_q;              // [R9]
						ind_wdata_d   = data_wr;
						win_d         = data_wr;
					end
					// no increment in hibernate; bursts are not expected there
					if (!hibernate) begin
						ptr_d = ptr_q + `IRAPM_PTR_STEP;    // [R5] [R6]
					end
				end
				irapm_pkg::irapm_xfer_direct: begin
					// plain direct register access
					if (read_q) begin
						rd_valid_d = 1'b1;
						if (addr_q == `IRAPM_PWR_ADDR) begin
							rd_data_d = pwr_q & `IRAPM_PWR_WMASK;
						end else begin
							rd_data_d = 8'h00;
						end
					end else if (addr_q == `IRAPM_PWR_ADDR) begin
						pwr_d = data_wr & `IRAPM_PWR_WMASK;
					end
					// direct burst steps on in every power state
					addr_d = addr_inc;                      // [R7]
					xfer_d = mode_of(addr_inc);             // [R7]
				end
				default: begin
					// byte outside a transaction is dropped
					xfer_d = irapm_pkg::irapm_xfer_idle;
				end
			endcase
		end
		if (xfer_end) begin
			// chip select released ends the transaction
			xfer_d = irapm_pkg::irapm_xfer_idle;
		end
		if (soft_reset) begin
			// soft reset reloads the power and window reset values but keeps the pointer
			pwr_d = `IRAPM_PWR_RESET;                       // [R8]
			win_d = `IRAPM_WIN_RESET;
		end
	end

	// register all state
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			xfer_q        <= irapm_pkg::irapm_xfer_idle;
			addr_q        <= '0;
			read_q        <= 1'b0;
			ptr_q         <= `IRAPM_PTR_RESET;
			win_q         <= `IRAPM_WIN_RESET;           // [R11]
			pwr_q         <= `IRAPM_PWR_RESET;
			rd_data_q     <= 8'h00;
			rd_valid_q    <= 1'b0;
			ind_wr_addr_q <= 8'h00;
			ind_wdata_q   <= 8'h00;
			ind_we_q      <= 1'b0;
			ind_re_q      <= 1'b0;
		end else begin
			xfer_q        <= xfer_d;
			addr_q        <= addr_d;
			read_q        <= read_d;
			ptr_q         <= ptr_d;
			win_q         <= win_d;
			pwr_q         <= pwr_d;
			rd_data_q     <= rd_data_d;
			rd_valid_q    <= rd_valid_d;
			ind_wr_addr_q <= ind_wr_addr_d;
			ind_wdata_q   <= ind_wdata_d;
			ind_we_q      <= ind_we_d;
			ind_re_q      <= ind_re_d;
		end
	end

	// pointer drives the indirect address; crystal bit leaves directly
	assign ind_addr_q           = ptr_q;
	assign crystal_osc_enable_q = pwr_q[`IRAPM_XTAL_BIT];

	// ***********************************************
	// power mode selection
	// ***********************************************

	// regulator mode and power state from the power mode register
	irapm_pmc_select u_pmc (
		.clk                    (clk),
		.reset_n                (reset_n),
		.auto_low_power_enable  (pwr_q[`IRAPM_AUTO_BIT]),
		.regulator_power_select (pwr_q[`IRAPM_SEL_BIT]),
		.crystal_osc_enable     (pwr_q[`IRAPM_XTAL_BIT]),
		.seq_active             (seq_active),
		.high_power_q           (pmc_high_power_q),
		.power_state_q          (power_state_q)
	);

	// ***********************************************
	// checks
	// ***********************************************

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// a data byte that no other event disturbs
	sequence quiet_byte_s;
		data_valid && !ctl_valid && !xfer_end;
	endsequence

	// control word at the pointer address followed by its byte
	sequence ptr_load_s;
		(ctl_valid && ctl_addr == `IRAPM_PTR_ADDR && !xfer_end) ##1 quiet_byte_s;
	endsequence

	ptr_load_a: assert property (ptr_load_s |=> ptr_q == $past(data_wr)
		&& xfer_q == irapm_pkg::irapm_xfer_window) // [R4]
		else $error("pointer byte not loaded");
	ptr_incr_a: assert property ((quiet_byte_s and // [R5]
		(xfer_q == irapm_pkg::irapm_xfer_window && !hibernate))
		|=> ptr_q == 8'($past(ptr_q) + `IRAPM_PTR_STEP))
		else $error("pointer did not increment");
	direct_incr_a: assert property ((quiet_byte_s and // [R7]
		(xfer_q == irapm_pkg::irapm_xfer_direct))
		|=> addr_q == `IRAPM_ADDR_W'($past(addr_q) + `IRAPM_ADDR_W'(1)))
		else $error("direct address did not increment");
	soft_keep_a: assert property (soft_reset && !data_valid |=> $stable(ptr_q)) // [R8]
		else $error("soft reset changed pointer");
	win_route_a: assert property ((quiet_byte_s and // [R9]
		(xfer_q == irapm_pkg::irapm_xfer_window && !read_q && ind_writable))
		|=> ind_we_q && ind_wr_addr_q == $past(ptr_q)
		&& ind_wdata_q == $past(data_wr))
		else $error("window write misrouted");
	ro_block_a: assert property ((quiet_byte_s and // [R10]
		(xfer_q == irapm_pkg::irapm_xfer_window && !ind_writable))
		|=> !ind_we_q)
		else $error("write to read-only target");
	win_reset_a: assert property (disable iff (1'b0) // [R11]
		!reset_n |=> win_q == `IRAPM_WIN_RESET)
		else $error("window not zero after reset");
	addr_map_a: assert property (ctl_valid && ctl_addr == `IRAPM_WIN_ADDR && !xfer_end
		|=> xfer_q == irapm_pkg::irapm_xfer_window) // [R12]
		else $error("window address not decoded");

endmodule : irapm_top

// ### verification/irapm_ind_space_model.sv
// far-side model of the indirect register space behind the window
`timescale 1ns/1ps

module irapm_ind_space_model #(
	parameter logic [7:0] RO_ADDR = 8'h00 // the one read-only location
) (
	// clock
	input  wire logic       clk,
	// access from the block
	input  wire logic [7:0] ind_addr_q,
	input  wire logic [7:0] ind_wr_addr_q,
	input  wire logic [7:0] ind_wdata_q,
	input  wire logic       ind_we_q,
	// answer to the block
	output logic [7:0]      ind_rdata,
	output logic            ind_writable
);
	// ************
	// storage
	// ************
	logic [7:0] mem [256]; // contents, seeded as address xor 5a

	// seed every location with a known pattern
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'h5a;
		end
	end

	// read data and access kind follow the pointer at once
	assign ind_rdata    = mem[ind_addr_q];
	assign ind_writable = (ind_addr_q != RO_ADDR);

	// writes land on the strobe, never on the read-only place
	always @(posedge clk) begin
		if (ind_we_q && (ind_wr_addr_q != RO_ADDR)) begin
			mem[ind_wr_addr_q] <= ind_wdata_q;
		end
	end
endmodule : irapm_ind_space_model

// ### verification/tb_indirect_register_access_pmc.sv
// self-checking bench for the indirect access and power mode block
`timescale 1ns/1ps

module tb_indirect_register_access_pmc;
	// ************
	// signals
	// ************
	logic       clk = 1'b0, reset_n = 1'b0; // clock and reset
	logic       ctl_valid = 1'b0, ctl_read = 1'b0; // control word
	logic [5:0] ctl_addr = 6'h00;
	logic       data_valid = 1'b0, xfer_end = 1'b0; // data bytes
	logic [7:0] data_wr = 8'h00;
	logic       soft_reset = 1'b0, seq_active = 1'b0;
	logic [7:0] rd_data_q, ind_addr_q, ind_wr_addr_q, ind_wdata_q, ind_rdata;
	logic       rd_valid_q, ind_we_q, ind_re_q, ind_writable;
	logic       pmc_high_power_q, crystal_osc_enable_q;
	irapm_pkg::irapm_pstate_type power_state_q;
	int         error_cnt = 0, cmp_count = 0; // tallies
	logic [7:0] pv [5] = '{8'h11, 8'h10, 8'h01, 8'h12, 8'h12}; // power table
	logic       sq [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
	logic       hp [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
	logic [1:0] st [5] = '{2'h2, 2'h1, 2'h3, 2'h1, 2'h1};

	always #2.5 clk = ~clk; // 200 MHz

	// ************
	// design and far side
	// ************
	irapm_top DUT (.clk(clk), .reset_n(reset_n), .ctl_valid(ctl_valid),
		.ctl_addr(ctl_addr), .ctl_read(ctl_read), .data_valid(data_valid),
		.data_wr(data_wr), .xfer_end(xfer_end), .rd_data_q(rd_data_q),
		.rd_valid_q(rd_valid_q), .ind_addr_q(ind_addr_q),
		.ind_wr_addr_q(ind_wr_addr_q), .ind_wdata_q(ind_wdata_q),
		.ind_we_q(ind_we_q), .ind_re_q(ind_re_q), .ind_rdata(ind_rdata),
		.ind_writable(ind_writable), .soft_reset(soft_reset),
		.seq_active(seq_active), .pmc_high_power_q(pmc_high_power_q),
		.power_state_q(power_state_q),
		.crystal_osc_enable_q(crystal_osc_enable_q));
	irapm_ind_space_model M (.clk(clk), .ind_addr_q(ind_addr_q),
		.ind_wr_addr_q(ind_wr_addr_q), .ind_wdata_q(ind_wdata_q),
		.ind_we_q(ind_we_q), .ind_rdata(ind_rdata), .ind_writable(ind_writable));

	// ************
	// tasks
	// ************
	// count and report one comparison
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// one cycle of framer strobes, driven just after the edge
	task stp(input logic c, input logic d, input logic x, input logic [5:0] a,
		input logic r, input logic [7:0] b);
		@(posedge clk);
		#1;
		ctl_valid  = c;
		data_valid = d;
		xfer_end   = x;
		ctl_addr   = a;
		ctl_read   = r;
		data_wr    = b;
	endtask : stp

	task cyc(input int n);
		repeat (n) stp(0, 0, 0, 6'h00, 0, 8'h00);
	endtask : cyc

	// single-byte write transaction
	task wr1(input logic [5:0] a, input logic [7:0] b);
		stp(1, 0, 0, a, 0, 8'h00);
		stp(0, 1, 0, 6'h00, 0, b);
		stp(0, 0, 1, 6'h00, 0, 8'h00);
		cyc(1);
	endtask : wr1

	// single-byte read transaction with answer check
	task rdv(input string n, input logic [5:0] a, input logic [7:0] e);
		stp(1, 0, 0, a, 1, 8'h00);
		stp(0, 1, 0, 6'h00, 0, 8'h00);
		cyc(1);
		chk("rd_valid", 8'h01, {7'h00, rd_valid_q});
		chk("ind_re", {7'h00, a == 6'h3f}, {7'h00, ind_re_q});
		chk(n, e, rd_data_q);
		stp(0, 0, 1, 6'h00, 0, 8'h00);
		cyc(1);
	endtask : rdv

	// verdict and end of run
	task results;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : results

	// watchdog against a hang
	initial begin
		#20000;
		error_cnt++;
		results;
	end

	// ************
	// tests
	// ************
	initial begin
		repeat (16) @(posedge clk);
		#1 reset_n = 1'b1;
		cyc(2);
		chk("xtal", 8'h01, {7'h00, crystal_osc_enable_q});
		chk("state", 8'h01, 8'(power_state_q));
		// pointer load then an indirect write burst
		stp(1, 0, 0, 6'h3e, 0, 8'h00);
		stp(0, 1, 0, 6'h00, 0, 8'h10);
		stp(0, 1, 0, 6'h00, 0, 8'ha1);
		stp(0, 1, 0, 6'h00, 0, 8'ha2);
		stp(0, 1, 0, 6'h00, 0, 8'ha3);
		stp(0, 0, 1, 6'h00, 0, 8'h00);
		cyc(2);
		chk("mem10", 8'ha1, M.mem[8'h10]);
		chk("mem12", 8'ha3, M.mem[8'h12]);
		chk("ptr", 8'h13, ind_addr_q);
		// reads through the window follow the pointer
		rdv("win13", 6'h3f, 8'h49);
		rdv("win14", 6'h3f, 8'h4e);
		// read-only target ignores the write
		wr1(6'h3e, 8'h00);
		stp(1, 0, 0, 6'h3f, 0, 8'h00);
		stp(0, 1, 0, 6'h00, 0, 8'h77);
		cyc(1);
		chk("we_ro", 8'h00, {7'h00, ind_we_q});
		stp(0, 0, 1, 6'h00, 0, 8'h00);
		wr1(6'h3e, 8'h00);
		rdv("mem00", 6'h3f, 8'h5a);
		// power select table, manual and automatic
		for (int i = 0; i < 5; i++) begin
			seq_active = sq[i];
			wr1(6'h03, pv[i]);
			cyc(2);
			chk("hp", {7'h00, hp[i]}, {7'h00, pmc_high_power_q});
			chk("state", {6'h00, st[i]}, 8'(power_state_q));
		end
		// hibernate: single indirect write, then direct burst
		wr1(6'h3e, 8'h30);
		wr1(6'h03, 8'h00);
		cyc(2);
		chk("state", 8'h00, 8'(power_state_q));
		wr1(6'h3f, 8'hc3);
		cyc(1);
		chk("mem30", 8'hc3, M.mem[8'h30]);
		chk("ptr_hib", 8'h30, ind_addr_q);
		stp(1, 0, 0, 6'h02, 0, 8'h00);
		stp(0, 1, 0, 6'h00, 0, 8'hff);
		stp(0, 1, 0, 6'h00, 0, 8'h11);
		stp(0, 0, 1, 6'h00, 0, 8'h00);
		cyc(3);
		chk("hp", 8'h01, {7'h00, pmc_high_power_q});
		chk("state", 8'h02, 8'(power_state_q));
		// soft reset keeps the pointer
		wr1(6'h3e, 8'h44);
		soft_reset = 1'b1;
		cyc(1);
		soft_reset = 1'b0;
		cyc(2);
		chk("ptr", 8'h44, ind_addr_q);
		rdv("pwr", 6'h03, 8'h10);
		rdv("unmapped", 6'h05, 8'h00);
		results;
	end
endmodule : tb_indirect_register_access_pmc
